// [pkg/utdb_pkg.sv]
// Purpose: Constants and carrier types for the transmit double-buffer path
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes: Register offsets below are aligned words
package utdb_pkg;
  localparam logic [7:0] UTDB_ADDR_CTRL = 8'h00;
  localparam logic [7:0] UTDB_ADDR_RELOAD = 8'h04;
  localparam logic [7:0] UTDB_ADDR_SHIFT = 8'h08;
  localparam logic [7:0] UTDB_ADDR_LINE_STAT = 8'h0c;
  localparam logic [7:0] UTDB_ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] UTDB_ADDR_IRQ_MASK = 8'h14;
  localparam int UTDB_CTRL_DELAY_EN_BIT = 0;
  localparam int UTDB_CTRL_FIFO_RST_BIT = 1;
  localparam int UTDB_LINE_HOLD_EMPTY_BIT = 5;
  localparam int UTDB_LINE_TX_EMPTY_BIT = 6;
  localparam int UTDB_IRQ_FULL_BIT = 0;
  localparam int UTDB_IRQ_HOST_EMPTY_BIT = 1;
  localparam int UTDB_IRQ_W = 2;
  localparam logic [15:0] UTDB_RELOAD_RESET = 16'h0100;
  localparam logic [31:0] UTDB_UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] data;
    logic full;
  } utdb_stage_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } utdb_wb_req_type;
endpackage

// [verilog/utdb_delay_timer.sv]
// Purpose: Character delay down-counter with timed-out state
// Assumes: Single clock, clock enable freezes the count
// Notes: Zero count is the timed-out state
`timescale 1ns/100ps
module utdb_delay_timer
  import utdb_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic force_timeout,
  input wire logic reload,
  input wire logic [CNT_W-1:0] reload_val,
  output logic timed_out
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  if (CNT_W < 2) begin : gen_cnt_w_check
    $error("CNT_W too small");
  end

  always_comb begin
    cnt_d = cnt_q;
    // Fifo reset must beat a transfer in the same cycle
    if (force_timeout) begin
      cnt_d = '0;
    end else if (reload) begin
      cnt_d = reload_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  assign timed_out = (cnt_q == '0);
endmodule

// [verilog/utdb_tx_path.sv]
// Purpose: Host holding register, shift buffer, empty flags, requests
// Assumes: Host write strobe on this clock; Wishbone for processor side
// Notes: Shift buffer read through Wishbone clears it
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module utdb_tx_path
  import utdb_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic delay_en,
  output logic host_holding_empty_flag,
  output logic host_tx_empty_flag,
  output logic proc_irq_request,
  output logic dma_request,
  output logic irq,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  utdb_stage_type hold_q, hold_d;
  utdb_stage_type shift_q, shift_d;
  logic host_empty_q, host_empty_d;
  logic proc_empty_q, proc_empty_d;
  logic hold_flag_q, hold_flag_d;
  logic irq_req_q, irq_req_d;
  logic dma_q, dma_d;
  logic irq_q, irq_d;
  logic delay_en_q, delay_en_d;
  logic [CNT_W-1:0] reload_q, reload_d;
  logic [UTDB_IRQ_W-1:0] stat_q, stat_d;
  logic [UTDB_IRQ_W-1:0] mask_q, mask_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic fifo_rst_q, fifo_rst_d;
  logic shift_read_q, shift_read_d;
  // Two flops bring the enable pin into this clock; the third spots a change
  logic cfg_meta_q, cfg_meta_d;
  logic cfg_sync_q, cfg_sync_d;
  logic cfg_seen_q, cfg_seen_d;
  logic timed_out;
  logic xfer;
  logic req;
  logic wr;
  logic rd;
  logic host_set;
  logic [31:0] line_word;
  logic [31:0] ctrl_word;

  if (CNT_W < 2 || CNT_W > 32) begin : gen_cnt_w_check
    $error("CNT_W out of range");
  end

  // Request decode; the ack cycle blocks a double take
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;

  // Delay mode waits on an empty shift buffer and idle timer
  assign xfer = hold_q.full && !shift_q.full &&
                (!delay_en_q || timed_out);

  // Host empty only rises once every stage has drained
  assign host_set = !host_empty_q && !hold_q.full && !shift_q.full &&
                    (!delay_en_q || (shift_read_q && timed_out));

  utdb_delay_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .force_timeout(fifo_rst_q || host_set),
    .reload(xfer),
    .reload_val(reload_q),
    .timed_out(timed_out)
  );

  always_comb begin
    line_word = '0;
    line_word[UTDB_LINE_TX_EMPTY_BIT] = proc_empty_q;
    line_word[UTDB_LINE_HOLD_EMPTY_BIT] = hold_flag_q;
    ctrl_word = '0;
    ctrl_word[UTDB_CTRL_DELAY_EN_BIT] = delay_en_q;
  end

  // Data path and flag next state
  always_comb begin
    hold_d = hold_q;
    shift_d = shift_q;
    shift_read_d = shift_read_q;
    if (xfer) begin
      shift_d.data = hold_q.data;
      shift_d.full = 1'b1;
      hold_d.full = 1'b0;
      shift_read_d = 1'b0;
    end
    if (host_wr && (!hold_q.full || xfer)) begin
      hold_d.data = host_wdata;
      hold_d.full = 1'b1;
    end
    if (rd && wb_adr_i == UTDB_ADDR_SHIFT && shift_q.full) begin
      shift_d.full = 1'b0;
      shift_read_d = 1'b1;
    end
    if (fifo_rst_q) begin
      hold_d.full = 1'b0;
      shift_d.full = 1'b0;
    end
    hold_flag_d = !hold_d.full;
    proc_empty_d = !shift_d.full;
    irq_req_d = shift_d.full;
    dma_d = shift_d.full;
    host_empty_d = host_empty_q;
    if (hold_d.full || shift_d.full) begin
      host_empty_d = 1'b0;
    end else if (host_set || fifo_rst_q) begin
      host_empty_d = 1'b1;
    end
  end

  // Register file next state
  always_comb begin
    delay_en_d = delay_en_q;
    reload_d = reload_q;
    mask_d = mask_q;
    fifo_rst_d = 1'b0;
    stat_d = stat_q;
    ack_d = req;
    rdat_d = UTDB_UNMAPPED_DATA;
    cfg_meta_d = delay_en;
    cfg_sync_d = cfg_meta_q;
    cfg_seen_d = cfg_sync_q;
    // Pin acts only on a change, so a software setting survives a steady pin
    if (cfg_sync_q != cfg_seen_q) begin
      delay_en_d = cfg_sync_q;
    end
    if (wr) begin
      if (wb_adr_i == UTDB_ADDR_CTRL) begin
        delay_en_d = wb_dat_i[UTDB_CTRL_DELAY_EN_BIT];
        fifo_rst_d = wb_dat_i[UTDB_CTRL_FIFO_RST_BIT];
      end else if (wb_adr_i == UTDB_ADDR_RELOAD) begin
        reload_d = wb_dat_i[CNT_W-1:0];
      end else if (wb_adr_i == UTDB_ADDR_IRQ_STAT) begin
        stat_d = stat_q & ~wb_dat_i[UTDB_IRQ_W-1:0];
      end else if (wb_adr_i == UTDB_ADDR_IRQ_MASK) begin
        mask_d = wb_dat_i[UTDB_IRQ_W-1:0];
      end
    end
    // Set wins over a clear in the same cycle
    if (xfer) begin
      stat_d[UTDB_IRQ_FULL_BIT] = 1'b1;
    end
    if (host_set) begin
      stat_d[UTDB_IRQ_HOST_EMPTY_BIT] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
    if (rd) begin
      if (wb_adr_i == UTDB_ADDR_CTRL) begin
        rdat_d = ctrl_word;
      end else if (wb_adr_i == UTDB_ADDR_RELOAD) begin
        rdat_d = 32'(reload_q);
      end else if (wb_adr_i == UTDB_ADDR_SHIFT) begin
        rdat_d = {24'h00_0000, shift_q.data};
      end else if (wb_adr_i == UTDB_ADDR_LINE_STAT) begin
        rdat_d = line_word;
      end else if (wb_adr_i == UTDB_ADDR_IRQ_STAT) begin
        rdat_d = 32'(stat_q);
      end else if (wb_adr_i == UTDB_ADDR_IRQ_MASK) begin
        rdat_d = 32'(mask_q);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= '0;
      shift_q <= '0;
      shift_read_q <= 1'b1;
      host_empty_q <= 1'b1;
      proc_empty_q <= 1'b1;
      hold_flag_q <= 1'b1;
      irq_req_q <= 1'b0;
      dma_q <= 1'b0;
      irq_q <= 1'b0;
      delay_en_q <= 1'b0;
      reload_q <= CNT_W'(UTDB_RELOAD_RESET);
      stat_q <= '0;
      mask_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= '0;
      fifo_rst_q <= 1'b0;
      cfg_meta_q <= 1'b0;
      cfg_sync_q <= 1'b0;
      cfg_seen_q <= 1'b0;
    end else if (clk_en) begin
      hold_q <= hold_d;
      shift_q <= shift_d;
      shift_read_q <= shift_read_d;
      host_empty_q <= host_empty_d;
      proc_empty_q <= proc_empty_d;
      hold_flag_q <= hold_flag_d;
      irq_req_q <= irq_req_d;
      dma_q <= dma_d;
      irq_q <= irq_d;
      delay_en_q <= delay_en_d;
      reload_q <= reload_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      fifo_rst_q <= fifo_rst_d;
      cfg_meta_q <= cfg_meta_d;
      cfg_sync_q <= cfg_sync_d;
      cfg_seen_q <= cfg_seen_d;
    end
  end

  assign host_holding_empty_flag = hold_flag_q;
  assign host_tx_empty_flag = host_empty_q;
  assign proc_irq_request = irq_req_q;
  assign dma_request = dma_q;
  assign irq = irq_q;
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // Flags are registered beside the stages, so they never lag them
  AST_HOLD_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en |=> hold_flag_q == !hold_q.full)
    else $error("holding-empty flag disagrees with holding register");
  AST_PROC_EMPTY: assert property (@(posedge clk) disable iff (!rst_b)
    proc_empty_q == !shift_q.full)
    else $error("processor empty flag lags shift buffer");
  AST_PROC_EMPTY_SET: assert property (@(posedge clk) disable iff (!rst_b)
    !shift_q.full |-> proc_empty_q)
    else $error("processor empty flag low with empty shift buffer");
  AST_REQ_FOLLOW: assert property (@(posedge clk) disable iff (!rst_b)
    irq_req_q == shift_q.full && dma_q == shift_q.full)
    else $error("irq or dma request not tracking shift buffer");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    irq_q == |(stat_q & mask_q))
    else $error("interrupt line disagrees with status and mask");
  AST_ACK_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && ack_q |=> !ack_q)
    else $error("acknowledge held longer than one cycle");

  // Data movement between the two stages
  AST_XFER_GATE: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && xfer && delay_en_q |-> timed_out && !shift_q.full)
    else $error("transfer without idle timer and empty shift buffer");
  AST_NO_EARLY_MOVE: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && delay_en_q && !timed_out && !shift_q.full |=> !shift_q.full)
    else $error("byte moved while delay timer still running");
  AST_SHIFT_DATA: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && xfer && !fifo_rst_q |=> shift_q.full && shift_q.data == $past(hold_q.data))
    else $error("shift buffer did not take the held byte");
  AST_HOLD_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && hold_q.full && !xfer && !fifo_rst_q
      |=> hold_q.full && hold_q.data == $past(hold_q.data))
    else $error("held byte lost or overwritten");
  AST_READ_EMPTIES: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && rd && wb_adr_i == UTDB_ADDR_SHIFT && shift_q.full |=> !shift_q.full)
    else $error("shift buffer still full after processor read");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && xfer && !fifo_rst_q |=> !timed_out || reload_q == '0)
    else $error("timer not reloaded on transfer");

  // Host transmitter-empty flag, timer state and delay enable pin load
  AST_HOST_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    hold_q.full || shift_q.full |-> !host_empty_q)
    else $error("host empty flag set while data held");
  AST_HOST_RISE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(host_empty_q) && $past(delay_en_q) && !$past(fifo_rst_q)
      |-> $past(shift_read_q) && $past(timed_out))
    else $error("host empty rose before timer expiry");
  AST_NODELAY: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !delay_en_q && !host_empty_q && !hold_q.full && !shift_q.full
      && !hold_d.full && !shift_d.full |=> host_empty_q)
    else $error("host empty not set with both stages empty");
  AST_TIMEOUT_ON_SET: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && host_set && !xfer |=> timed_out)
    else $error("timer not timed out after host empty set");
  AST_FIFO_RST: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && fifo_rst_q |=> !hold_q.full && !shift_q.full && host_empty_q && timed_out)
    else $error("fifo reset left data or a running timer");
  AST_CFG_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && cfg_sync_q != cfg_seen_q && !(wr && wb_adr_i == UTDB_ADDR_CTRL)
      |=> delay_en_q == $past(cfg_sync_q))
    else $error("delay enable pin change not loaded");

  COV_XFER: cover property (@(posedge clk) disable iff (!rst_b) xfer);
  COV_READ: cover property (@(posedge clk) disable iff (!rst_b)
    $fell(shift_q.full));
  COV_HOST_SET: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(host_empty_q) && delay_en_q);
  COV_IRQ: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq_q));
  COV_FIFO_RST: cover property (@(posedge clk) disable iff (!rst_b)
    fifo_rst_q && delay_en_q);
endmodule

// [test/utdb_host_model.sv]
// Purpose: Host side that writes bytes into the holding register
// Assumes: One byte per send pulse, host waits for holding-empty
// Notes: Data lines toggle between writes so stale bytes never pass
`timescale 1ns/100ps
module utdb_host_model
  import utdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic host_holding_empty_flag,
  output logic host_wr,
  output logic [7:0] host_wdata
);
  logic pend_q;
  logic gap_q;
  logic [7:0] byte_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      gap_q <= 1'b0;
      byte_q <= 8'h00;
      host_wr <= 1'b0;
      host_wdata <= 8'h00;
    end else begin
      host_wr <= 1'b0;
      gap_q <= host_wr;
      host_wdata <= ~host_wdata;
      if (send) begin
        pend_q <= 1'b1;
        byte_q <= send_byte;
      // Flag lags a write by a cycle, so skip two cycles after one
      end else if (pend_q && host_holding_empty_flag && !host_wr && !gap_q) begin
        host_wr <= 1'b1;
        host_wdata <= byte_q;
        pend_q <= 1'b0;
      end
    end
  end
endmodule

// [test/uart_tx_double_buffer_test.sv]
// Purpose: Self-checking bench for the transmit double-buffer path
// Assumes: Bench is the processor on Wishbone, host model sends bytes
// Notes: Delay reload cut to 40 cycles to keep runs short
`timescale 1ns/100ps
module uart_tx_double_buffer_test
  import utdb_pkg::*;
;
  localparam int W_PREQ = 0;
  localparam int W_TXE = 1;
  logic clk, rst_b, ce, delay_en, send, host_wr, cyc, stb, we;
  logic [7:0] send_byte, host_wdata, adr;
  logic [31:0] wdat, rdat, wb_dat_o;
  logic hold_e, tx_e, preq, dreq, irq, wb_ack_o;
  int mismatches, n_tests, n;
  utdb_tx_path #(.CNT_W(16)) uut (.clk(clk), .rst_b(rst_b), .clk_en(ce),
    .host_wr(host_wr), .host_wdata(host_wdata), .delay_en(delay_en),
    .host_holding_empty_flag(hold_e), .host_tx_empty_flag(tx_e),
    .proc_irq_request(preq), .dma_request(dreq), .irq(irq), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  utdb_host_model host (.clk(clk), .rst_b(rst_b), .send(send), .send_byte(send_byte),
    .host_holding_empty_flag(hold_e), .host_wr(host_wr), .host_wdata(host_wdata));
  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk1(logic got, logic exp, string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic chk32(logic [31:0] got, logic [31:0] exp, string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rdat = wb_dat_o;
    if (k >= 50) begin
      mismatches++;
      $display("Error at %0t: no acknowledge", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~d;
    @(posedge clk);
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp, string what);
    wb(1'b0, a, 32'h0000_0000);
    chk32(rdat, exp, what);
  endtask
  task automatic hsend(logic [7:0] b);
    send <= 1'b1;
    send_byte <= b;
    @(posedge clk);
    send <= 1'b0;
  endtask
  function automatic logic pick(int which);
    return (which == W_PREQ) ? preq : tx_e;
  endfunction
  task automatic wait_on(int which, logic v);
    n = 0;
    while (pick(which) !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      $display("Error at %0t: wait timed out", $time);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    // Whole run is well under 6000 cycles
    #150000;
    mismatches++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    {delay_en, send, cyc, stb, we} = 5'h00;
    ce = 1'b1;
    {send_byte, adr, wdat} = 48'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk1(hold_e & tx_e & !preq & !dreq, 1'b1, "reset flags");
    rd_chk(UTDB_ADDR_LINE_STAT, 32'h0000_0060, "status reset");
    rd_chk(UTDB_ADDR_RELOAD, 32'h0000_0100, "reload reset");
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rd_chk(8'h20, UTDB_UNMAPPED_DATA, "unmapped");
    wb(1'b1, UTDB_ADDR_RELOAD, 32'h0000_0028);
    rd_chk(UTDB_ADDR_RELOAD, 32'h0000_0028, "reload");
    wb(1'b1, UTDB_ADDR_IRQ_MASK, 32'h0000_0003);
    hsend(8'h5a);
    wait_on(W_PREQ, 1'b1);
    chk1(dreq & !tx_e, 1'b1, "dma or tx empty");
    rd_chk(UTDB_ADDR_LINE_STAT, 32'h0000_0020, "status full");
    rd_chk(UTDB_ADDR_SHIFT, 32'h0000_005a, "shift");
    chk1(preq | dreq, 1'b0, "req after read");
    rd_chk(UTDB_ADDR_LINE_STAT, 32'h0000_0060, "status empty");
    chk1(tx_e, 1'b1, "tx empty");
    rd_chk(UTDB_ADDR_IRQ_STAT, 32'h0000_0003, "status");
    chk1(irq, 1'b1, "irq");
    wb(1'b1, UTDB_ADDR_IRQ_MASK, 32'h0000_0000);
    chk1(irq, 1'b0, "irq masked");
    wb(1'b1, UTDB_ADDR_IRQ_MASK, 32'h0000_0003);
    wb(1'b1, UTDB_ADDR_IRQ_STAT, 32'h0000_0003);
    chk1(irq, 1'b0, "irq cleared");
    delay_en <= 1'b1;
    @(posedge clk);
    hsend(8'ha1);
    wait_on(W_PREQ, 1'b1);
    chk1(n < 6, 1'b1, "first move late");
    hsend(8'hb2);
    repeat (4) @(posedge clk);
    chk1(hold_e, 1'b0, "second held");
    rd_chk(UTDB_ADDR_SHIFT, 32'h0000_00a1, "shift a");
    // Frozen cycles must stretch the delay, not eat into it
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    chk1(preq, 1'b0, "frozen move");
    ce <= 1'b1;
    wait_on(W_PREQ, 1'b1);
    chk1(n > 20 && n < 60, 1'b1, "delay move");
    chk1(tx_e, 1'b0, "tx empty early");
    rd_chk(UTDB_ADDR_SHIFT, 32'h0000_00b2, "shift b");
    wait_on(W_TXE, 1'b1);
    chk1(n > 20 && n < 60, 1'b1, "tx empty delay");
    hsend(8'hc3);
    wait_on(W_PREQ, 1'b1);
    hsend(8'hd4);
    repeat (4) @(posedge clk);
    wb(1'b1, UTDB_ADDR_CTRL, 32'h0000_0003);
    chk1(hold_e & tx_e & !preq & !dreq, 1'b1, "fifo reset");
    hsend(8'he5);
    wait_on(W_PREQ, 1'b1);
    chk1(n < 6, 1'b1, "move after fifo reset");
    rd_chk(UTDB_ADDR_SHIFT, 32'h0000_00e5, "shift e");
    end_of_test();
  end
endmodule
